// ---- pkg/gcf_pkg.sv ----
// Purpose: constants shared by the global config / fault zone block
// Assumes: 8 channels, two zones of four, 8-bit command data
// Notes: command codes are local choices of this block
package gcf_pkg;

  // channel and zone layout
  localparam int NUM_CH = 8;
  localparam int ZONE_CH = 4;
  localparam int NUM_ZONE = 2;
  localparam int NUM_LINE = 4;

  // command codes for the three registers
  localparam logic [7:0] CMD_GLOBAL_CONFIG = 8'hd1;
  localparam logic [7:0] CMD_PROP_FIRST = 8'hd2;
  localparam logic [7:0] CMD_PROP_SECOND = 8'hd3;

  // global config field positions
  localparam int GC_FAULT_LOG = 7;
  localparam int GC_VIN_CLR = 6;
  localparam int GC_POL_SECOND = 5;
  localparam int GC_POL_FIRST = 4;
  localparam int GC_SHARE_INH = 3;
  localparam int GC_PEC_REQ = 2;
  localparam int GC_LONG_TMO = 1;
  localparam int GC_WPU_DIS = 0;

  // propagate register: only bit 0 is stored
  localparam int PROP_BIT = 0;

  // reset values
  localparam logic [7:0] GLOBAL_CONFIG_RST = 8'h00;
  localparam logic [7:0] PROP_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // timeout multipliers
  localparam logic [3:0] TMO_MULT_NORMAL = 4'h1;
  localparam logic [3:0] TMO_MULT_LONG = 4'h8;

  // synchroniser width: two start pins, share clock, four zone lines
  localparam int SYNC_W = 7;
  localparam int SY_START_FIRST = 0;
  localparam int SY_START_SECOND = 1;
  localparam int SY_SHARE = 2;
  localparam int SY_ZONE = 3;

endpackage : gcf_pkg

// ---- core/gcf_sync.sv ----
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module gcf_sync
  import gcf_pkg::*;
#(
  parameter int W = SYNC_W
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [W-1:0] async_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } gcf_sync_t;

  gcf_sync_t st_reg;
  gcf_sync_t st_next;

  // shift the pin through two stages
  always_comb begin
    st_next.meta = async_i;
    st_next.stable = st_reg.meta;
  end

  // reset both stages to the caller's idle level, so no false edge follows reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_reg.meta <= rst_val_i;
      st_reg.stable <= rst_val_i;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.stable;

endmodule : gcf_sync

// ---- core/gcf_zone_map.sv ----
// Purpose: map four channels of one zone onto its two fault lines
// Assumes: line inputs are already synchronised, low = asserted
// Notes: purely combinational; the top registers the results
`timescale 1ns/10ps
module gcf_zone_map
  import gcf_pkg::*;
(
  input wire logic [ZONE_CH-1:0] faulted_off_i,
  input wire logic [ZONE_CH-1:0] prop_first_i,
  input wire logic [ZONE_CH-1:0] prop_second_i,
  input wire logic [ZONE_CH-1:0] resp_first_i,
  input wire logic [ZONE_CH-1:0] resp_second_i,
  input wire logic line_a_low_i,
  input wire logic line_b_low_i,
  output logic pull_a_o,
  output logic pull_b_o,
  output logic [ZONE_CH-1:0] shut_o
);

  // any propagating faulted-off channel pulls its line
  assign pull_a_o = |(faulted_off_i & prop_first_i);
  assign pull_b_o = |(faulted_off_i & prop_second_i);

  // a low line stops only channels whose response is set
  assign shut_o = ({ZONE_CH{line_a_low_i}} & resp_first_i) |
                  ({ZONE_CH{line_b_low_i}} & resp_second_i);

endmodule : gcf_zone_map

// ---- core/gcf_top.sv ----
// Purpose: global config byte and per-page fault zone propagation
// Assumes: command engine decodes bus traffic and supplies page
// Notes: zone lines and share clock are open-drain, oe_n low drives
//
// Summary of operation
// - fault records go to nonvolatile memory only when bit 7 is set.
// - with bit 6 set, input-on rising edge clears all latched faults.
// - bit 5 picks the active level of the second start input.
// - bit 4 picks the active level of the first start input.
// - with bit 3 set, share clock held low while input is off.
// - with bit 3 set, share clock seen low turns all channels off.
// - bit 2 set makes packet error check mandatory, else optional.
// - bit 1 set multiplies the bus timeout by eight.
// - bit 0 clear enables input-enable weak pull-up, else three-state.
// - global byte applies to all channels, reachable from any page.
// - pages 0-3 use zone 0 lines, pages 4-7 zone 1 lines.
// - first propagate bit lets faulted-off channel pull line a low.
// - second propagate bit lets faulted-off channel pull line b low.
// - propagate bits 7 to 1 ignore writes and read zero.
// - channels with response zero keep running when zone line low.
// - zone shutdown drives alert low and sets a status bit.
`timescale 1ns/10ps
module gcf_top
  import gcf_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // command port from the bus engine
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [2:0] cmd_page_i,
  input wire logic [7:0] cmd_wdata_i,
  output logic [7:0] cmd_rdata_o,
  output logic cmd_rvalid_o,
  // internal device status
  input wire logic vin_on_i,
  input wire logic fault_event_i,
  input wire logic powered_up_i,
  input wire logic vin_en_forced_off_i,
  input wire logic [NUM_CH-1:0] faulted_off_i,
  input wire logic [NUM_CH-1:0] resp_first_i,
  input wire logic [NUM_CH-1:0] resp_second_i,
  // pins
  input wire logic first_start_input_i,
  input wire logic second_start_input_i,
  input wire logic share_clk_i,
  output logic share_clk_o,
  output logic share_clk_oe_n_o,
  input wire logic [NUM_LINE-1:0] zone_fault_line_i,
  output logic [NUM_LINE-1:0] zone_fault_line_o,
  output logic [NUM_LINE-1:0] zone_fault_line_oe_n_o,
  // controls to the rest of the device
  output logic fault_log_req_o,
  output logic clear_faults_o,
  output logic first_start_active_o,
  output logic second_start_active_o,
  output logic all_off_o,
  output logic pec_required_o,
  output logic [3:0] timeout_mult_o,
  output logic vin_en_wpu_en_o,
  output logic vin_en_tristate_o,
  output logic [NUM_CH-1:0] zone_shutdown_o,
  output logic [NUM_CH-1:0] status_zone_set_o,
  output logic alert_n_o
);

  //////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0] gcfg;
    logic [NUM_CH-1:0] prop_first;
    logic [NUM_CH-1:0] prop_second;
    logic [7:0] rdata;
    logic rvalid;
    logic vin_on_d;
    logic clr_faults;
    logic log_req;
    logic start_first;
    logic start_second;
    logic share_lvl;
    logic share_oe_n;
    logic all_off;
    logic pec_req;
    logic [3:0] tmo_mult;
    logic wpu_en;
    logic vinen_tri;
    logic [NUM_LINE-1:0] zone_lvl;
    logic [NUM_LINE-1:0] zone_oe_n;
    logic [NUM_CH-1:0] shut;
    logic [NUM_CH-1:0] stat_set;
    logic alert_n;
  } gcf_state_t;

  gcf_state_t st_reg;
  gcf_state_t st_next;

  logic [SYNC_W-1:0] pins_sync;
  logic [NUM_ZONE-1:0] pull_a;
  logic [NUM_ZONE-1:0] pull_b;
  logic [NUM_CH-1:0] shut_now;

  //////////////////////////////////////////////////////////////////
  // pin synchronisers

  gcf_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .async_i({zone_fault_line_i, share_clk_i,
              second_start_input_i, first_start_input_i}),
    .rst_val_i('1),
    .sync_o(pins_sync)
  );

  //////////////////////////////////////////////////////////////////
  // zone mapping, one instance per zone

  // zone z owns channels 4z..4z+3 and lines 2z, 2z+1
  for (genvar z = 0; z < NUM_ZONE; z++) begin : g_zone
    gcf_zone_map u_map (
      .faulted_off_i(faulted_off_i[z*ZONE_CH +: ZONE_CH]),
      .prop_first_i(st_reg.prop_first[z*ZONE_CH +: ZONE_CH]),
      .prop_second_i(st_reg.prop_second[z*ZONE_CH +: ZONE_CH]),
      .resp_first_i(resp_first_i[z*ZONE_CH +: ZONE_CH]),
      .resp_second_i(resp_second_i[z*ZONE_CH +: ZONE_CH]),
      .line_a_low_i(~pins_sync[SY_ZONE + 2*z]),
      .line_b_low_i(~pins_sync[SY_ZONE + 2*z + 1]),
      .pull_a_o(pull_a[z]),
      .pull_b_o(pull_b[z]),
      .shut_o(shut_now[z*ZONE_CH +: ZONE_CH])
    );
  end

  //////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;

    // register writes; global byte ignores the page
    if (cmd_wr_i) begin
      unique case (cmd_code_i)
        CMD_GLOBAL_CONFIG: st_next.gcfg = cmd_wdata_i;
        CMD_PROP_FIRST: begin
          st_next.prop_first[cmd_page_i] = cmd_wdata_i[PROP_BIT];
        end
        CMD_PROP_SECOND: begin
          st_next.prop_second[cmd_page_i] = cmd_wdata_i[PROP_BIT];
        end
        default: ;
      endcase
    end

    // reads answer one cycle later; unknown codes read zero
    st_next.rvalid = cmd_rd_i;
    st_next.rdata = RDATA_RST;
    if (cmd_rd_i) begin
      unique case (cmd_code_i)
        CMD_GLOBAL_CONFIG: st_next.rdata = st_reg.gcfg;
        CMD_PROP_FIRST: begin
          st_next.rdata = {7'h00, st_reg.prop_first[cmd_page_i]};
        end
        CMD_PROP_SECOND: begin
          st_next.rdata = {7'h00, st_reg.prop_second[cmd_page_i]};
        end
        default: ;
      endcase
    end

    // logging gate
    st_next.log_req = fault_event_i & st_reg.gcfg[GC_FAULT_LOG];

    // input-on edge clears latched faults
    st_next.vin_on_d = vin_on_i;
    st_next.clr_faults = vin_on_i & ~st_reg.vin_on_d &
                         st_reg.gcfg[GC_VIN_CLR];

    // start inputs are active when the pin matches polarity
    st_next.start_second = ~(pins_sync[SY_START_SECOND] ^
                             st_reg.gcfg[GC_POL_SECOND]);
    st_next.start_first = ~(pins_sync[SY_START_FIRST] ^
                            st_reg.gcfg[GC_POL_FIRST]);

    // share clock inhibit: drive low while input is off
    st_next.share_lvl = 1'b0;
    st_next.share_oe_n = ~(st_reg.gcfg[GC_SHARE_INH] & ~vin_on_i);
    // seen low from anyone, ourselves included, stops every channel
    st_next.all_off = st_reg.gcfg[GC_SHARE_INH] &
                      ~pins_sync[SY_SHARE];

    // bus engine controls
    st_next.pec_req = st_reg.gcfg[GC_PEC_REQ];
    st_next.tmo_mult = st_reg.gcfg[GC_LONG_TMO] ?
                       TMO_MULT_LONG : TMO_MULT_NORMAL;

    // input-enable pull-up only once up and not forced off
    st_next.wpu_en = ~st_reg.gcfg[GC_WPU_DIS] & powered_up_i &
                     ~vin_en_forced_off_i;
    st_next.vinen_tri = st_reg.gcfg[GC_WPU_DIS] & powered_up_i &
                        ~vin_en_forced_off_i;

    // zone line drivers, low level only
    st_next.zone_lvl = '0;
    for (int z = 0; z < NUM_ZONE; z++) begin
      st_next.zone_oe_n[2*z] = ~pull_a[z];
      st_next.zone_oe_n[2*z+1] = ~pull_b[z];
    end

    // zone shutdown and its status / alert pulse
    st_next.shut = shut_now;
    st_next.stat_set = shut_now & ~st_reg.shut;
    st_next.alert_n = ~|(shut_now & ~st_reg.shut);
  end

  //////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_reg <= '0;
      st_reg.gcfg <= GLOBAL_CONFIG_RST;
      st_reg.prop_first <= PROP_RST;
      st_reg.prop_second <= PROP_RST;
      st_reg.share_lvl <= 1'b0;
      st_reg.share_oe_n <= 1'b1;
      st_reg.tmo_mult <= TMO_MULT_NORMAL;
      st_reg.zone_oe_n <= '1;
      st_reg.alert_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign cmd_rdata_o = st_reg.rdata;
  assign cmd_rvalid_o = st_reg.rvalid;
  assign fault_log_req_o = st_reg.log_req;
  assign clear_faults_o = st_reg.clr_faults;
  assign first_start_active_o = st_reg.start_first;
  assign second_start_active_o = st_reg.start_second;
  assign share_clk_o = st_reg.share_lvl;
  assign share_clk_oe_n_o = st_reg.share_oe_n;
  assign all_off_o = st_reg.all_off;
  assign pec_required_o = st_reg.pec_req;
  assign timeout_mult_o = st_reg.tmo_mult;
  assign vin_en_wpu_en_o = st_reg.wpu_en;
  assign vin_en_tristate_o = st_reg.vinen_tri;
  assign zone_fault_line_o = st_reg.zone_lvl;
  assign zone_fault_line_oe_n_o = st_reg.zone_oe_n;
  assign zone_shutdown_o = st_reg.shut;
  assign status_zone_set_o = st_reg.stat_set;
  assign alert_n_o = st_reg.alert_n;

endmodule : gcf_top

// ---- tb/gcf_top_sva.sv ----
// Purpose: port checks for gcf_top
// Assumes: global byte mirrored from command writes
// Notes: bound to every gcf_top instance below
`timescale 1ns/10ps
module gcf_top_sva
  import gcf_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic [7:0] cmd_rdata_o,
  input wire logic cmd_rvalid_o,
  input wire logic vin_on_i,
  input wire logic fault_event_i,
  input wire logic share_clk_oe_n_o,
  input wire logic fault_log_req_o,
  input wire logic clear_faults_o,
  input wire logic all_off_o,
  input wire logic pec_required_o,
  input wire logic [3:0] timeout_mult_o,
  input wire logic [NUM_CH-1:0] zone_shutdown_o,
  input wire logic [NUM_CH-1:0] status_zone_set_o,
  input wire logic alert_n_o
);
  logic [7:0] gc_q;
  wire gc_hit = cmd_code_i == CMD_GLOBAL_CONFIG;
  // mirror updates on the same edge as the block's own register
  always_ff @(posedge clk_sys_i)
    gc_q <= srst_i ? GLOBAL_CONFIG_RST : (cmd_wr_i && gc_hit ? cmd_wdata_i : gc_q);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////
  // answers and config levels, one edge behind their cause
  property p_rd; cmd_rd_i && gc_hit |=> cmd_rdata_o == $past(gc_q); endproperty
  a_rd: assert property (p_rd) else $error("global read wrong");
  property p_rv;
    cmd_rvalid_o == $past(cmd_rd_i) && (cmd_rvalid_o || cmd_rdata_o == 8'h00);
  endproperty
  a_rv: assert property (p_rv) else $error("read answer wrong");
  property p_log; fault_log_req_o == $past(fault_event_i && gc_q[GC_FAULT_LOG]); endproperty
  a_log: assert property (p_log) else $error("log request wrong");
  property p_clr;
    clear_faults_o == ($past(vin_on_i && gc_q[GC_VIN_CLR]) && !$past(vin_on_i, 2));
  endproperty
  a_clr: assert property (p_clr) else $error("clear pulse wrong");
  property p_pec; pec_required_o == $past(gc_q[GC_PEC_REQ]); endproperty
  a_pec: assert property (p_pec) else $error("pec level wrong");
  property p_tmo;
    timeout_mult_o == ($past(gc_q[GC_LONG_TMO]) ? TMO_MULT_LONG : TMO_MULT_NORMAL);
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout factor wrong");
  property p_shr; share_clk_oe_n_o == !$past(gc_q[GC_SHARE_INH] && !vin_on_i); endproperty
  a_shr: assert property (p_shr) else $error("share drive wrong");
  // own drive held low must be seen after the two sync stages
  property p_off; !share_clk_oe_n_o [*4] |-> all_off_o; endproperty
  a_off: assert property (p_off) else $error("all off missing");
  property p_aln; alert_n_o == !(|(zone_shutdown_o & ~$past(zone_shutdown_o))); endproperty
  a_aln: assert property (p_aln) else $error("alert wrong");
  property p_set; status_zone_set_o == (zone_shutdown_o & ~$past(zone_shutdown_o)); endproperty
  a_set: assert property (p_set) else $error("status set wrong");
  c_rd: cover property (cmd_rvalid_o);
  c_clr: cover property (clear_faults_o);
  c_aln: cover property (!alert_n_o);
endmodule : gcf_top_sva
bind gcf_top gcf_top_sva i_sva (.*);

// ---- tb/gcf_partner.sv ----
// Purpose: companion managers on the shared open-drain lines
// Assumes: pull-ups hold released lines high
// Notes: extra pulls are commanded by the bench
`timescale 1ns/10ps
module gcf_partner
  import gcf_pkg::*;
(
  input wire logic own_share_oe_n_i,
  input wire logic [NUM_LINE-1:0] own_zone_oe_n_i,
  input wire logic pull_share_i,
  input wire logic [NUM_LINE-1:0] pull_zone_i,
  output logic share_o,
  output logic [NUM_LINE-1:0] zone_o
);
  // wired-low: any party pulling wins, else the pull-up
  assign share_o = own_share_oe_n_i & ~pull_share_i;
  assign zone_o = own_zone_oe_n_i & ~pull_zone_i;
endmodule : gcf_partner

// ---- tb/tb_global_config_fault_propagation.sv ----
// Purpose: directed register and pin checks of gcf_top
// Assumes: inputs change 1 ns after the rising edge
// Notes: expectations come from the field map only
`timescale 1ns/10ps
module tb_global_config_fault_propagation;
  import gcf_pkg::*;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, wr = 1'b0, rd = 1'b0, vin = 1'b0, fev = 1'b0;
  logic pwr = 1'b1, frc = 1'b0, st0 = 1'b0, st1 = 1'b0, psh = 1'b0, shw, rv, lg, clr;
  logic a0, a1, off, pec, shoe, wpu, tsd, aln, shl;
  logic [7:0] code = 8'h00, wd = 8'h00, fo = 8'h00, ra = 8'h00, rb = 8'h00, rdt, zsd, zset;
  logic [7:0] cv [4] = '{8'h00, 8'h15, 8'h26, 8'h33};
  logic [2:0] pg = 3'h0;
  logic [3:0] pz = 4'h0, zw, zoe, tmo, zl;
  int error_cnt = 0, checks = 0, cyc = 0;
  gcf_top i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .cmd_wr_i(wr), .cmd_rd_i(rd),
    .cmd_code_i(code), .cmd_page_i(pg), .cmd_wdata_i(wd), .cmd_rdata_o(rdt), .cmd_rvalid_o(rv),
    .vin_on_i(vin), .fault_event_i(fev), .powered_up_i(pwr), .vin_en_forced_off_i(frc),
    .faulted_off_i(fo), .resp_first_i(ra), .resp_second_i(rb), .first_start_input_i(st0),
    .second_start_input_i(st1), .share_clk_i(shw), .share_clk_o(shl), .share_clk_oe_n_o(shoe),
    .zone_fault_line_i(zw), .zone_fault_line_o(zl), .zone_fault_line_oe_n_o(zoe),
    .fault_log_req_o(lg), .clear_faults_o(clr), .first_start_active_o(a0),
    .second_start_active_o(a1), .all_off_o(off), .pec_required_o(pec), .timeout_mult_o(tmo),
    .vin_en_wpu_en_o(wpu), .vin_en_tristate_o(tsd), .zone_shutdown_o(zsd),
    .status_zone_set_o(zset), .alert_n_o(aln));
  gcf_partner i_far (.own_share_oe_n_i(shoe), .own_zone_oe_n_i(zoe), .pull_share_i(psh),
    .pull_zone_i(pz), .share_o(shw), .zone_o(zw));
  // 8 ns period
  always #4 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // strobes are one-cycle pulses, code and data held with them
  task automatic wrr(input logic [7:0] c, input logic [2:0] p, input logic [7:0] d);
    tick(1);
    wr = 1'b1;
    code = c;
    pg = p;
    wd = d;
    tick(1);
    wr = 1'b0;
  endtask : wrr
  task automatic rdr(input logic [7:0] c, input logic [2:0] p, input logic [7:0] e);
    tick(1);
    rd = 1'b1;
    code = c;
    pg = p;
    tick(1);
    rd = 1'b0;
    cmp("rvalid", 8'h01, {7'h00, rv});
    cmp("rdata", e, rdt);
  endtask : rdr
  task automatic test_done();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // hang guard, the run needs under two hundred cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    tick(20);
    srst_i = 1'b0;
    rdr(CMD_GLOBAL_CONFIG, 3'h3, GLOBAL_CONFIG_RST);
    rdr(CMD_PROP_SECOND, 3'h7, PROP_RST);
    wrr(CMD_GLOBAL_CONFIG, 3'h5, 8'h5a);
    wrr(8'h00, 3'h0, 8'hff);
    rdr(8'h00, 3'h0, RDATA_RST);
    rdr(CMD_GLOBAL_CONFIG, 3'h2, 8'h5a);
    for (int p = 0; p < NUM_CH; p++) begin
      wrr(CMD_PROP_FIRST, 3'(p), 8'hff);
      wrr(CMD_PROP_SECOND, 3'(p), 8'hfe);
      rdr(CMD_PROP_FIRST, 3'(p), 8'h01);
      rdr(CMD_PROP_SECOND, 3'(p), 8'h00);
    end
    // pins move with the config so every polarity pairing occurs
    foreach (cv[i]) begin
      st0 = cv[i][2];
      st1 = cv[i][0];
      wrr(CMD_GLOBAL_CONFIG, 3'h0, cv[i]);
      tick(3);
      cmp("pec", {7'h00, cv[i][2]}, {7'h00, pec});
      cmp("tmo", cv[i][1] ? 8'h08 : 8'h01, {4'h0, tmo});
      cmp("wpu", {6'h00, !cv[i][0], cv[i][0]}, {6'h00, wpu, tsd});
      cmp("start", {6'h00, cv[i][5] == st1, cv[i][4] == st0}, {6'h00, a1, a0});
    end
    frc = 1'b1;
    tick(2);
    cmp("wpu", 8'h00, {6'h00, wpu, tsd});
    frc = 1'b0;
    // before power-up neither pull-up nor three-state is applied
    pwr = 1'b0;
    tick(2);
    cmp("wpu", 8'h00, {6'h00, wpu, tsd});
    pwr = 1'b1;
    for (int k = 0; k < 2; k++) begin
      wrr(CMD_GLOBAL_CONFIG, 3'h0, k ? 8'hc0 : 8'h00);
      fev = 1'b1;
      vin = 1'b1;
      tick(1);
      cmp("log", 8'(k), {7'h00, lg});
      cmp("clr", 8'(k), {7'h00, clr});
      fev = 1'b0;
      vin = 1'b0;
    end
    // share line: released, own hold, then a companion pull
    tick(1);
    vin = 1'b1;
    wrr(CMD_GLOBAL_CONFIG, 3'h0, 8'h08);
    tick(4);
    cmp("share", 8'h02, {6'h00, shoe, off});
    vin = 1'b0;
    tick(4);
    cmp("share", 8'h01, {6'h00, shoe, off});
    vin = 1'b1;
    psh = 1'b1;
    tick(5);
    cmp("share", 8'h03, {6'h00, shoe, off});
    wrr(CMD_GLOBAL_CONFIG, 3'h0, 8'h00);
    tick(1);
    cmp("share", 8'h02, {6'h00, shoe, off});
    psh = 1'b0;
    // zones: ch2 pulls zone0 a, ch6 zone1 b, companion zone1 a
    wrr(CMD_PROP_FIRST, 3'h6, 8'h00);
    wrr(CMD_PROP_SECOND, 3'h6, 8'h01);
    fo = 8'h44;
    ra = 8'h10;
    tick(4);
    cmp("pull", 8'h06, {4'h0, zoe});
    cmp("level", 8'h00, {3'h0, shl, zl});
    cmp("stop", 8'h00, zsd);
    pz = 4'h4;
    tick(3);
    cmp("stop", 8'h10, zsd);
    cmp("alert", 8'h10, zset | {aln, 7'h00});
    srst_i = 1'b1;
    tick(3);
    srst_i = 1'b0;
    rdr(CMD_PROP_FIRST, 3'h2, PROP_RST);
    cmp("pull", 8'h0f, {4'h0, zoe});
    test_done();
  end
endmodule : tb_global_config_fault_propagation
